// *** core/pfc_pkg.sv ***
// constants, carriers and rule summary for the port 2 flow control register block
// Overview of operation
// - bit 6 read/write: 1 allows half-duplex backpressure, 0 forbids it
// - bit 5 read-only: current duplex, 0 full, 1 half
// - bit 4 read-only: receive pause currently in effect
// - bit 3 read-only: transmit pause currently in effect
// - bit 2 enables pause detection when manual or negotiation is off
// - bit 1 enables pause generation when manual or negotiation is off
// - bit 0 clear with negotiation on: negotiated result rules, manual bits ignored
// - bit 0 set: manual enables alone decide flow control in full duplex
// - writable bits take their reset value from straps latched after reset release
// - an eeprom reload of the straps rewrites the matching register bits
// - status bits start from a combination of several straps
// - writes never alter the transceiver advertisement values
// - bits 31 to 7 are reserved, read zero, ignore writes
`default_nettype none
package pfc_pkg;

	// register map, byte address on the ahb-lite bus
	localparam logic [31:0] FC_CFG_ADDR = 32'h0000_01A4;

	// field positions inside the register word
	localparam int BIT_MANUAL = 0;
	localparam int BIT_TX_EN = 1;
	localparam int BIT_RX_EN = 2;
	localparam int BIT_CUR_TX = 3;
	localparam int BIT_CUR_RX = 4;
	localparam int BIT_CUR_DUPLEX = 5;
	localparam int BIT_BACKPRESSURE = 6;
	localparam int RSVD_LSB = 7;

	// field values before the straps have been captured
	localparam logic RST_FIELD = 1'b0;

	// ahb-lite encodings used by the slave
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;

	// cycles from reset release until synchronised straps are trusted
	localparam int STRAP_SETTLE_CYCLES = 3;
	localparam int STRAP_W = 5;

	// configuration straps, also the layout the eeprom loader delivers
	typedef struct packed {
		logic autoneg;
		logic half_duplex;
		logic manual_select;
		logic pause_enable;
		logic backpressure;
	} pfc_strap_s;

	// live result from the negotiation engine, same clock domain
	typedef struct packed {
		logic valid;
		logic enable;
		logic half_duplex;
		logic rx_pause;
		logic tx_pause;
	} pfc_neg_s;

	// controls handed to the port mac
	typedef struct packed {
		logic backpressure_enable;
		logic half_duplex;
		logic rx_pause_detect;
		logic tx_pause_generate;
	} pfc_ctrl_s;

	// control state machine
	typedef enum logic [1:0] {
		ST_SETTLE = 2'b01,
		ST_RUN = 2'b10
	} pfc_state_e;

endpackage
`default_nettype wire

// *** core/pfc_sync.sv ***
// two flip-flop synchroniser for a group of strap pins
`default_nettype none
module pfc_sync #(
	parameter int W = 5
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_ff;

	// first stage feeds only the second stage
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= '0;
			sync_out <= '0;
		end else begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule
`default_nettype wire

// *** core/pfc_port_regs.sv ***
// port 2 flow control configuration register with ahb-lite slave
//
// Our own choice: the AHB-Lite interface to the registers.
`default_nettype none
module pfc_port_regs
	import pfc_pkg::*;
#(
	parameter int SETTLE_CYCLES = STRAP_SETTLE_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire pfc_strap_s strap_pins,
	input wire logic eeprom_load,
	input wire pfc_strap_s eeprom_straps,
	input wire pfc_neg_s neg_status,
	output pfc_ctrl_s port_ctrl
);

	// resolve duplex and pause enables: returns {half, rx, tx}
	function automatic logic [2:0] resolve_fc(
		input logic manual,
		input logic rx_en,
		input logic tx_en,
		input logic an_en,
		input logic an_rx,
		input logic an_tx,
		input logic half
	);
		logic rx;
		logic tx;
		rx = 1'b0;
		tx = 1'b0;
		// pause frames only exist in full duplex
		if (!half) begin
			if (manual || !an_en) begin
				rx = rx_en;
				tx = tx_en;
			end else begin
				rx = an_rx;
				tx = an_tx;
			end
		end
		return {half, rx, tx};
	endfunction

	// assemble the register word, reserved bits forced to zero
	function automatic logic [31:0] compose_word(
		input logic bp,
		input logic half,
		input logic cur_rx,
		input logic cur_tx,
		input logic rx_en,
		input logic tx_en,
		input logic manual
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[BIT_BACKPRESSURE] = bp;
		w[BIT_CUR_DUPLEX] = half;
		w[BIT_CUR_RX] = cur_rx;
		w[BIT_CUR_TX] = cur_tx;
		w[BIT_RX_EN] = rx_en;
		w[BIT_TX_EN] = tx_en;
		w[BIT_MANUAL] = manual;
		return w;
	endfunction

	pfc_strap_s strap_sync;
	pfc_state_e state_ff;
	pfc_state_e nxt_state;
	logic [3:0] settle_cnt_ff;
	logic strap_load;
	logic eeprom_take;
	logic addr_phase;
	logic addr_hit;
	logic wr_pend_ff;
	logic hit_ff;
	logic sw_write;
	logic bp_en_ff;
	logic rx_en_ff;
	logic tx_en_ff;
	logic manual_ff;
	logic nxt_bp_en;
	logic nxt_rx_en;
	logic nxt_tx_en;
	logic nxt_manual;
	logic cur_half_ff;
	logic cur_rx_ff;
	logic cur_tx_ff;
	logic [2:0] nxt_status;
	logic [2:0] strap_status;
	logic [31:0] hrdata_ff;

	// strap pins come from outside the clock domain
	pfc_sync #(
		.W(STRAP_W)
	) u_strap_sync (
		.clock(clock),
		.nrst(nrst),
		.async_in(strap_pins),
		.sync_out(strap_sync)
	);

	// control state machine: wait for the synchroniser, then run
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_SETTLE: begin
				if (settle_cnt_ff == 4'(SETTLE_CYCLES - 1)) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				nxt_state = ST_RUN;
			end
			default: begin
				nxt_state = ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_ff <= ST_SETTLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// settle counter; a strap is caught after release, never under reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			settle_cnt_ff <= 4'h0;
		end else if (state_ff == ST_SETTLE) begin
			settle_cnt_ff <= settle_cnt_ff + 4'h1;
		end
	end

	// one pulse as the settle phase ends latches the straps
	assign strap_load = (state_ff == ST_SETTLE) && (nxt_state == ST_RUN);
	assign eeprom_take = (state_ff == ST_RUN) && eeprom_load;

	// address phase decode; bus stalls until straps are latched
	assign hreadyout = (state_ff == ST_RUN);
	assign hresp = HRESP_OKAY;
	assign addr_phase = hsel && (htrans == HTRANS_NONSEQ) && hready;
	assign addr_hit = (haddr == FC_CFG_ADDR);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wr_pend_ff <= 1'b0;
			hit_ff <= 1'b0;
		end else if (hready) begin
			// narrow writes are ignored rather than merged per byte lane
			wr_pend_ff <= addr_phase && hwrite && (hsize == HSIZE_WORD);
			hit_ff <= addr_phase && addr_hit;
		end
	end

	assign sw_write = wr_pend_ff && hit_ff;

	// writable fields: eeprom reload beats a software write in the same cycle
	always_comb begin
		nxt_bp_en = bp_en_ff;
		nxt_rx_en = rx_en_ff;
		nxt_tx_en = tx_en_ff;
		nxt_manual = manual_ff;
		// only bits 6, 2, 1 and 0 take write data; 31 to 7 are dropped
		if (sw_write) begin
			nxt_bp_en = hwdata[BIT_BACKPRESSURE];
			nxt_rx_en = hwdata[BIT_RX_EN];
			nxt_tx_en = hwdata[BIT_TX_EN];
			nxt_manual = hwdata[BIT_MANUAL];
		end
		if (strap_load) begin
			nxt_bp_en = strap_sync.backpressure;
			nxt_rx_en = strap_sync.pause_enable;
			nxt_tx_en = strap_sync.pause_enable;
			nxt_manual = strap_sync.manual_select;
		end
		if (eeprom_take) begin
			nxt_bp_en = eeprom_straps.backpressure;
			nxt_rx_en = eeprom_straps.pause_enable;
			nxt_tx_en = eeprom_straps.pause_enable;
			nxt_manual = eeprom_straps.manual_select;
		end
	end

	// register file holds only its own fields; advertisement lives in the transceiver
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			bp_en_ff <= RST_FIELD;
			rx_en_ff <= RST_FIELD;
			tx_en_ff <= RST_FIELD;
			manual_ff <= RST_FIELD;
		end else begin
			bp_en_ff <= nxt_bp_en;
			rx_en_ff <= nxt_rx_en;
			tx_en_ff <= nxt_tx_en;
			manual_ff <= nxt_manual;
		end
	end

	// strap-derived status stands until the negotiation engine reports, or until manual_ff set recomputes it from the enables
	assign strap_status = eeprom_take
		? resolve_fc(eeprom_straps.manual_select, eeprom_straps.pause_enable,
			eeprom_straps.pause_enable, eeprom_straps.autoneg, eeprom_straps.pause_enable,
			eeprom_straps.pause_enable, eeprom_straps.half_duplex)
		: resolve_fc(strap_sync.manual_select, strap_sync.pause_enable,
			strap_sync.pause_enable, strap_sync.autoneg, strap_sync.pause_enable,
			strap_sync.pause_enable, strap_sync.half_duplex);

	// status bits: live resolution once the engine is valid
	always_comb begin
		nxt_status = {cur_half_ff, cur_rx_ff, cur_tx_ff};
		if (strap_load || (eeprom_take && !neg_status.valid)) begin
			nxt_status = strap_status;
		end else if ((state_ff == ST_RUN) && neg_status.valid) begin
			nxt_status = resolve_fc(manual_ff, rx_en_ff, tx_en_ff, neg_status.enable,
				neg_status.rx_pause, neg_status.tx_pause, neg_status.half_duplex);
		end else if ((state_ff == ST_RUN) && manual_ff) begin
			// no engine result yet: manual enables still decide, duplex stays as last known
			nxt_status = resolve_fc(1'b1, rx_en_ff, tx_en_ff, 1'b1,
				cur_rx_ff, cur_tx_ff, cur_half_ff);
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cur_half_ff <= RST_FIELD;
			cur_rx_ff <= RST_FIELD;
			cur_tx_ff <= RST_FIELD;
		end else begin
			cur_half_ff <= nxt_status[2];
			cur_rx_ff <= nxt_status[1];
			cur_tx_ff <= nxt_status[0];
		end
	end

	// read data captured at the address phase; forwarding nxt_ covers write-then-read
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			if (addr_hit) begin
				hrdata_ff <= compose_word(nxt_bp_en, cur_half_ff, cur_rx_ff, cur_tx_ff,
					nxt_rx_en, nxt_tx_en, nxt_manual);
			end else begin
				hrdata_ff <= 32'h0000_0000; // unmapped reads answer zero
			end
		end
	end

	assign hrdata = hrdata_ff;

	// port controls straight from flops
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			port_ctrl <= '0;
		end else begin
			port_ctrl.backpressure_enable <= nxt_bp_en;
			port_ctrl.half_duplex <= nxt_status[2];
			port_ctrl.rx_pause_detect <= nxt_status[1];
			port_ctrl.tx_pause_generate <= nxt_status[0];
		end
	end

	default clocking cb @(posedge clock);
	endclocking

	default disable iff (!nrst);

	// a read address phase to this register, one cycle, without its data phase
	sequence rd_cfg_s;
		addr_phase && !hwrite && addr_hit;
	endsequence

	// manual or negotiation-off resolution in full duplex
	sequence manual_full_s;
		(state_ff == ST_RUN) && neg_status.valid && !neg_status.half_duplex
			&& !strap_load && !eeprom_take && (manual_ff || !neg_status.enable);
	endsequence

	// negotiated resolution in full duplex
	sequence auto_full_s;
		(state_ff == ST_RUN) && neg_status.valid && !neg_status.half_duplex
			&& !eeprom_take && !manual_ff && neg_status.enable;
	endsequence

	rsvd_zero_a: assert property (hrdata[31:RSVD_LSB] == 25'h0)
		else $error("reserved read bits not zero");

	bp_write_a: assert property (sw_write && !eeprom_take
		|=> port_ctrl.backpressure_enable == $past(hwdata[BIT_BACKPRESSURE]))
		else $error("backpressure enable did not take write data");

	duplex_read_a: assert property (rd_cfg_s ##1 1'b1
		|-> hrdata[BIT_CUR_DUPLEX] == $past(cur_half_ff))
		else $error("duplex read back wrong");

	pause_read_a: assert property (rd_cfg_s |=> (hrdata[BIT_CUR_RX] == $past(cur_rx_ff))
		&& (hrdata[BIT_CUR_TX] == $past(cur_tx_ff)))
		else $error("pause status read back wrong");

	tx_status_a: assert property (rd_cfg_s
		|=> hrdata[BIT_CUR_TX] == $past(port_ctrl.tx_pause_generate))
		else $error("transmit status read back differs from control");

	manual_rx_a: assert property (manual_full_s
		|=> cur_rx_ff == $past(rx_en_ff))
		else $error("manual receive pause not applied");

	manual_tx_a: assert property (manual_full_s
		|=> cur_tx_ff == $past(tx_en_ff))
		else $error("manual transmit pause not applied");

	neg_follow_a: assert property (auto_full_s
		|=> (cur_rx_ff == $past(neg_status.rx_pause)) && (cur_tx_ff == $past(neg_status.tx_pause)))
		else $error("negotiated pause result not applied");

	strap_latch_a: assert property (strap_load |=> (bp_en_ff == $past(strap_sync.backpressure))
		&& (manual_ff == $past(strap_sync.manual_select)) && (rx_en_ff == $past(strap_sync.pause_enable)))
		else $error("strap values not latched");

	eeprom_reload_a: assert property (eeprom_take |=> (bp_en_ff == $past(eeprom_straps.backpressure))
		&& (manual_ff == $past(eeprom_straps.manual_select))
		&& (tx_en_ff == $past(eeprom_straps.pause_enable)))
		else $error("eeprom reload not applied");

	strap_status_a: assert property (strap_load
		|=> cur_half_ff == $past(strap_sync.half_duplex))
		else $error("duplex status not derived from straps");

	half_quiet_a: assert property (cur_half_ff |-> !cur_rx_ff && !cur_tx_ff)
		else $error("pause active in half duplex");

	bus_stall_a: assert property ((state_ff == ST_SETTLE) |-> !hreadyout ##1 1'b1)
		else $error("bus ready before straps latched");

endmodule
`default_nettype wire

// *** verification/pfc_port_regs_bench.sv ***
// self-checking bench for the port 2 flow control register over ahb-lite
`default_nettype none
module pfc_port_regs_bench
	import pfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clock, nrst, hsel, hwrite, hready, hreadyout, hresp, eeprom_load;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	pfc_strap_s strap_pins, eeprom_straps;
	pfc_neg_s neg_status;
	pfc_ctrl_s port_ctrl;
	int bad_count, checks, i;

	// single slave, so its ready is the bus ready
	assign hready = hreadyout;

	pfc_port_regs #(.SETTLE_CYCLES(3)) i_dut (
		.clock(clock),
		.nrst(nrst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.strap_pins(strap_pins),
		.eeprom_load(eeprom_load),
		.eeprom_straps(eeprom_straps),
		.neg_status(neg_status),
		.port_ctrl(port_ctrl)
	);

	// 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// reference word: half duplex kills pause, manual or no negotiation uses the enables
	function automatic logic [31:0] fc_word(input logic bp, half, man, rxe, txe, an, nrx, ntx);
		logic cr, ct;
		cr = half ? 1'b0 : ((man | ~an) ? rxe : nrx);
		ct = half ? 1'b0 : ((man | ~an) ? txe : ntx);
		return {25'h0, bp, half, cr, ct, rxe, txe, man};
	endfunction

	// the pause strap feeds both enables and also stands in for the negotiated result
	function automatic logic [31:0] strap_word(input pfc_strap_s s);
		return fc_word(s.backpressure, s.half_duplex, s.manual_select, s.pause_enable, s.pause_enable,
			s.autoneg, s.pause_enable, s.pause_enable);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("mismatches %0d of %0d compares", bad_count, checks);
		if (bad_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// bounded wait for hready sampled high at a rising edge
	task automatic wait_ready();
		int n;
		logic rdy;
		n = 0;
		do begin
			// sample in the low half: this is the value standing at the next rising edge
			@(negedge clock);
			rdy = hreadyout;
			rdv = hrdata;
			@(posedge clock);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk(32'h1, 32'h0);
		end
	endtask

	// one single transfer: address phase, then data phase, read data taken at the closing edge
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= sz;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, HSIZE_WORD, d);
	endtask

	// status lags field updates, so let a few edges pass before reading back
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		repeat (3) @(posedge clock);
		xfer(1'b0, a, HSIZE_WORD, 32'h0);
		chk(rdv, exp);
		if (a == FC_CFG_ADDR) begin
			chk({28'h0, port_ctrl}, {28'h0, exp[6], exp[5], exp[4], exp[3]});
		end
	endtask

	task automatic do_reset(input pfc_strap_s s);
		strap_pins <= s;
		nrst <= 1'b0;
		repeat (10) @(posedge clock);
		chk({31'h0, hreadyout}, 32'h0);
		chk({28'h0, port_ctrl}, 32'h0);
		nrst <= 1'b1;
	endtask

	// watchdog, well beyond the few hundred cycles the tests need
	initial begin
		#(40 * 5000);
		bad_count++;
		end_sim();
	end

	initial begin
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		eeprom_load = 1'b0;
		eeprom_straps = 5'h00;
		neg_status = 5'h00;
		strap_pins = 5'h13;
		bad_count = 0;
		checks = 0;
		@(posedge clock);
		// negotiated straps with pause and backpressure on
		do_reset(5'h13);
		rd_chk(FC_CFG_ADDR, strap_word(5'h13));
		$display("test straps done");
		// reserved and status bits ignore writes
		wr(FC_CFG_ADDR, 32'hFFFF_FFFF);
		rd_chk(FC_CFG_ADDR, fc_word(1, 0, 1, 1, 1, 1, 1, 1));
		wr(FC_CFG_ADDR, 32'h0000_0001);
		rd_chk(FC_CFG_ADDR, fc_word(0, 0, 1, 0, 0, 1, 1, 1));
		$display("test reserved done");
		// every mix of duplex, manual, enables and negotiation; negotiated pause opposes the enables
		for (i = 0; i < 32; i++) begin
			neg_status <= {1'b1, i[0], i[4], ~i[2], ~i[1]};
			wr(FC_CFG_ADDR, {25'h0, i[3], 3'h0, i[2], i[1], i[3]});
			rd_chk(FC_CFG_ADDR, fc_word(i[3], i[4], i[3], i[2], i[1], i[0], ~i[2], ~i[1]));
		end
		$display("test resolution done");
		// narrow write and unmapped address leave the register alone
		xfer(1'b1, FC_CFG_ADDR, 3'h0, 32'h0);
		wr(FC_CFG_ADDR + 32'h4, 32'h0);
		rd_chk(FC_CFG_ADDR + 32'h4, 32'h0);
		rd_chk(FC_CFG_ADDR, fc_word(1, 1, 1, 1, 1, 1, 0, 0));
		$display("test refusals done");
		// loader rewrites straps; negotiation idle so status falls back to strap resolution
		neg_status <= 5'h00;
		eeprom_straps <= 5'h05;
		eeprom_load <= 1'b1;
		@(posedge clock);
		eeprom_load <= 1'b0;
		rd_chk(FC_CFG_ADDR, strap_word(5'h05));
		$display("test eeprom done");
		// second reset mid-run with half duplex straps
		do_reset(5'h1E);
		rd_chk(FC_CFG_ADDR, strap_word(5'h1E));
		$display("test second reset done");
		end_sim();
	end
endmodule
`default_nettype wire
